// File: logic/upsc_pkg.sv
// Constants, register layout and carrier types for the port suspend control block.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
// Notes on behaviour
// - The suspend flag resets to zero and reads one only while the port is suspended.
// - The port state is disabled when enable is zero, enabled for enable one and suspend zero, suspended for both one.
// - While suspended, all downstream data is blocked except port reset signalling.
// - After a suspend request the flag reads one only once the port is idle and has entered suspend.
// - The flag is cleared unconditionally when software changes the resume force flag from one to zero.
// - A software write of zero to the suspend flag has no effect.
// - Resume force is set by software or by a J-to-K transition while suspended, and drives K while it is one.
// - Only the controller enables the port; a software write of one to the enable flag does not enable it.
package upsc_pkg;
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] stat_offset = 12'h004;
  localparam int ctrl_suspend_bit = 7;
  localparam int ctrl_resume_bit = 6;
  localparam int ctrl_enable_bit = 2;
  localparam int stat_state_lsb = 0;
  localparam int stat_halted_bit = 4;
  localparam int stat_pending_bit = 5;
  localparam logic suspend_reset = 1'b0;
  localparam logic resume_reset = 1'b0;
  localparam logic enable_reset = 1'b0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {upsc_disabled, upsc_enabled, upsc_suspended} upsc_state_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } upsc_data_s;
endpackage

// File: logic/upsc_top.sv
// Suspend control for one root hub port with an AXI4-Lite register slave.
// Assumes port reset, resume timing and fault handling sit in neighbouring logic.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module upsc_top #(
  parameter int addr_width = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic controller_halted_flag,
  input wire logic port_enable_set,
  input wire logic port_disable_fault,
  input wire logic port_reset_active,
  input wire logic port_activity,
  input wire logic line_j_to_k,
  input wire logic resume_done,
  input wire upsc_pkg::upsc_data_s down_in,
  output upsc_pkg::upsc_data_s down_out,
  output logic drive_resume_k,
  output logic suspend_pending
);
  if (addr_width < 12)
  begin : width_check
    $error("addr_width must be at least 12");
  end

  logic suspend_reg;
  logic suspend_next;
  logic resume_reg;
  logic resume_next;
  logic enable_reg;
  logic enable_next;
  logic pend_reg;
  logic pend_next;
  logic [addr_width-1:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  upsc_pkg::upsc_data_s down_reg;
  upsc_pkg::upsc_state_e state;

  wire aw_take = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
  wire w_take = s_axi_wvalid && !w_held_reg && !bvalid_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [11:0] wr_word = {awaddr_reg[11:2], 2'h0};
  wire wr_ctrl = wr_fire && (wr_word == upsc_pkg::ctrl_offset) && wstrb_reg[0];
  wire wr_hit = (wr_word == upsc_pkg::ctrl_offset) || (wr_word == upsc_pkg::stat_offset);
  wire w_suspend = wdata_reg[upsc_pkg::ctrl_suspend_bit];
  wire w_resume = wdata_reg[upsc_pkg::ctrl_resume_bit];
  wire w_enable = wdata_reg[upsc_pkg::ctrl_enable_bit];
  wire ar_take = s_axi_arvalid && !rvalid_reg;
  wire [11:0] rd_word = {s_axi_araddr[11:2], 2'h0};
  wire resume_fall = resume_reg && !resume_next;
  wire hw_resume = suspend_reg && line_j_to_k;
  wire enter_suspend = pend_reg && !port_activity && enable_reg;
  wire [31:0] ctrl_word = {24'h0, suspend_reg, resume_reg, 3'h0, enable_reg, 2'h0};
  wire [31:0] stat_word = {26'h0, pend_reg, controller_halted_flag, 2'h0, 2'(state)};
  wire block_down = suspend_reg && !port_reset_active;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign down_out = down_reg;
  assign drive_resume_k = resume_reg;
  assign suspend_pending = pend_reg;

  assign state = !enable_reg ? upsc_pkg::upsc_disabled :
                 (suspend_reg ? upsc_pkg::upsc_suspended : upsc_pkg::upsc_enabled);

  always_comb
  begin
    resume_next = resume_reg;
    if (wr_ctrl && !w_resume && !resume_done)
    begin
      resume_next = 1'b0;
    end
    if ((wr_ctrl && w_resume) || hw_resume)
    begin
      resume_next = 1'b1;
    end
  end

  always_comb
  begin
    enable_next = enable_reg;
    if ((wr_ctrl && !w_enable) || port_disable_fault)
    begin
      enable_next = 1'b0;
    end
    if (port_enable_set)
    begin
      enable_next = 1'b1;
    end
  end

  always_comb
  begin
    pend_next = pend_reg;
    if (enter_suspend || resume_fall || !enable_reg)
    begin
      pend_next = 1'b0;
    end
    if (wr_ctrl && w_suspend && enable_reg && !suspend_reg && !enter_suspend)
    begin
      pend_next = 1'b1;
    end
  end

  always_comb
  begin
    suspend_next = suspend_reg;
    if (enter_suspend)
    begin
      suspend_next = 1'b1;
    end
    if (resume_fall || !enable_next)
    begin
      suspend_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      suspend_reg <= upsc_pkg::suspend_reset;
      resume_reg <= upsc_pkg::resume_reset;
      enable_reg <= upsc_pkg::enable_reset;
      pend_reg <= 1'b0;
      down_reg <= '0;
    end
    else
    begin
      suspend_reg <= suspend_next;
      resume_reg <= resume_next;
      enable_reg <= enable_next;
      pend_reg <= pend_next;
      down_reg.valid <= down_in.valid && !block_down;
      down_reg.data <= block_down ? 8'h00 : down_in.data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= upsc_pkg::resp_okay;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? upsc_pkg::resp_okay : upsc_pkg::resp_slverr;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= upsc_pkg::resp_okay;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      if (rd_word == upsc_pkg::ctrl_offset)
      begin
        rdata_reg <= ctrl_word;
        rresp_reg <= upsc_pkg::resp_okay;
      end
      else if (rd_word == upsc_pkg::stat_offset)
      begin
        rdata_reg <= stat_word;
        rresp_reg <= upsc_pkg::resp_okay;
      end
      else
      begin
        rdata_reg <= 32'h0;
        rresp_reg <= upsc_pkg::resp_slverr;
      end
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  chk_suspend_reset_zero: assert property (@(posedge aclk) !aresetn |=> !suspend_reg)
    else $error("suspend flag not zero after reset");
  chk_state_decode_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == upsc_pkg::upsc_suspended) == (enable_reg && suspend_reg))
    else $error("port state decode wrong");
  chk_down_blocked_suspend: assert property (@(posedge aclk) disable iff (!aresetn)
    (suspend_reg && !port_reset_active) |=> !down_reg.valid)
    else $error("downstream data passed while suspended");
  chk_suspend_after_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(suspend_reg) |-> $past(pend_reg) && !$past(port_activity))
    else $error("suspend flag rose before port went idle");
  chk_resume_fall_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(resume_reg) |-> !suspend_reg)
    else $error("suspend flag kept after resume ended");
  chk_zero_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && !w_suspend && suspend_reg && !resume_fall && enable_next) |=> suspend_reg)
    else $error("write of zero cleared suspend flag");
  chk_hw_resume_set: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_resume |=> resume_reg && drive_resume_k)
    else $error("J-to-K while suspended did not force resume");
  chk_enable_hw_only: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(enable_reg) |-> $past(port_enable_set))
    else $error("port enabled without controller sequence");
  chk_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped before it was taken");
  chk_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped before it was taken");
  chk_down_passes_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (port_reset_active && down_in.valid) |=> down_reg.valid)
    else $error("reset signalling blocked downstream");
  chk_fault_disables_port: assert property (@(posedge aclk) disable iff (!aresetn)
    (port_disable_fault && !port_enable_set) |=> state == upsc_pkg::upsc_disabled)
    else $error("fault did not disable the port");
  chk_enable_write_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && w_enable && !enable_reg && !port_enable_set) |=> !enable_reg)
    else $error("software write enabled the port");
  chk_resume_k_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (drive_resume_k && !wr_ctrl) |=> drive_resume_k)
    else $error("resume signalling stopped while flag was set");
  chk_pending_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(suspend_reg) |-> !pend_reg)
    else $error("suspend request still pending after entry");
  chk_wr_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !wr_hit) |=> s_axi_bresp == upsc_pkg::resp_slverr)
    else $error("unmapped write not answered with error");
  chk_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read address taken without data");
  chk_halted_status: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_word == upsc_pkg::stat_offset)
    |=> s_axi_rdata[upsc_pkg::stat_halted_bit] == $past(controller_halted_flag))
    else $error("halted flag not shown in status");
  chk_pending_status: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_word == upsc_pkg::stat_offset)
    |=> s_axi_rdata[upsc_pkg::stat_pending_bit] == $past(pend_reg))
    else $error("pending flag not shown in status");
  chk_sw_disable_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && !w_enable && !port_enable_set) |=> !enable_reg && !suspend_reg)
    else $error("software disable left port enabled or suspended");
  chk_ctrl_read_suspend: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_word == upsc_pkg::ctrl_offset)
    |=> s_axi_rdata[upsc_pkg::ctrl_suspend_bit] == $past(suspend_reg))
    else $error("suspend flag not shown in control word");
endmodule

// File: tb/upsc_dev_model.sv
// Behavioural USB device on the downstream side of the port.
// Assumes it shares the controller clock and reset.
`timescale 1ns/10ps
module upsc_dev_model #(
  parameter int busy_len = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire upsc_pkg::upsc_data_s down_out,
  input wire logic wake,
  output logic port_activity,
  output logic line_j_to_k
);
  logic [7:0] busy_reg;
  logic wake_reg;
  assign port_activity = busy_reg != 8'h00;
  assign line_j_to_k = wake && !wake_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_reg <= 8'h00;
      wake_reg <= 1'b0;
    end
    else
    begin
      wake_reg <= wake;
      if (down_out.valid)
        busy_reg <= 8'(busy_len);
      else if (port_activity)
        busy_reg <= busy_reg - 8'h01;
    end
  end
endmodule

// File: tb/tb_top.sv
// Bench for the port suspend control block.
// Assumes the device model answers on the downstream port.
`timescale 1ns/10ps
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake;
  logic controller_halted_flag, port_enable_set, port_disable_fault, port_reset_active;
  logic port_activity, line_j_to_k, resume_done, drive_resume_k, suspend_pending;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  upsc_pkg::upsc_data_s down_in, down_out;
  int errors, num_checks, n;
  upsc_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .controller_halted_flag(controller_halted_flag), .port_enable_set(port_enable_set),
    .port_disable_fault(port_disable_fault), .port_reset_active(port_reset_active),
    .port_activity(port_activity), .line_j_to_k(line_j_to_k), .resume_done(resume_done),
    .down_in(down_in), .down_out(down_out), .drive_resume_k(drive_resume_k),
    .suspend_pending(suspend_pending)
  );
  upsc_dev_model dev (
    .aclk(aclk), .aresetn(aresetn), .down_out(down_out), .wake(wake),
    .port_activity(port_activity), .line_j_to_k(line_j_to_k)
  );
  task results();
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] st(input logic e, input logic s);
    return !e ? 32'h0 : (s ? 32'h2 : 32'h1);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40 && !b; i++)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid;
      rb = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b)
    begin
      chk("bvalid", 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40 && !r; i++)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      r = s_axi_rvalid;
      rq = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r)
    begin
      chk("rvalid", 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic send(input logic blk);
    logic [7:0] v;
    v = 8'(xs());
    @(posedge aclk);
    down_in <= '{1'b1, v};
    @(posedge aclk);
    down_in <= '{1'b0, 8'h00};
    @(negedge aclk);
    chk("down_out", 32'(down_out), blk ? 32'h0 : {23'h0, 1'b1, v});
    @(posedge aclk);
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wake} = 7'h00;
    {port_enable_set, port_disable_fault, port_reset_active, resume_done} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    down_in = '{1'b0, 8'h00};
    errors = 0;
    num_checks = 0;
    seed = 32'h0000b911;
    controller_halted_flag = 1'(xs());
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    s_axi_wstrb <= 4'hf;
    rd(12'h000);
    chk("ctrl", rq, 32'h0);
    rd(12'h004);
    chk("state", 32'(rq[1:0]), st(0, 0));
    chk("halted", 32'(rq[4]), 32'(controller_halted_flag));
    controller_halted_flag <= 1'b0;
    wr(12'h000, 32'h4);
    chk("bresp", 32'(rb), 32'(upsc_pkg::resp_okay));
    rd(12'h004);
    chk("sw_enable", 32'(rq[1:0]), st(0, 0));
    @(posedge aclk);
    port_enable_set <= 1'b1;
    @(posedge aclk);
    port_enable_set <= 1'b0;
    rd(12'h004);
    chk("hc_enable", 32'(rq[1:0]), st(1, 0));
    send(0);
    wr(12'h000, 32'h84);
    @(negedge aclk);
    chk("pending", 32'(suspend_pending), 32'h1);
    rd(12'h000);
    chk("early_suspend", 32'(rq[7]), 32'h0);
    for (n = 0; n < 100 && port_activity; n++)
      @(negedge aclk);
    if (n == 100)
    begin
      chk("activity", 32'h1, 32'h0);
      results();
    end
    rd(12'h000);
    chk("suspend", 32'(rq[7]), 32'h1);
    rd(12'h004);
    chk("suspended", 32'(rq[1:0]), st(1, 1));
    send(1);
    port_reset_active <= 1'b1;
    send(0);
    port_reset_active <= 1'b0;
    wr(12'h000, 32'h4);
    rd(12'h000);
    chk("write0", 32'(rq[7]), 32'h1);
    @(posedge aclk);
    wake <= 1'b1;
    rd(12'h000);
    wake <= 1'b0;
    chk("resume", 32'(rq[6]), 32'h1);
    @(negedge aclk);
    chk("resume_k", 32'(drive_resume_k), 32'h1);
    wr(12'h000, 32'h4);
    rd(12'h000);
    chk("clear", 32'(rq[7:6]), 32'h0);
    wr(12'h000, 32'h0);
    rd(12'h004);
    chk("sw_disable", 32'(rq[1:0]), st(0, 0));
    @(posedge aclk);
    port_enable_set <= 1'b1;
    @(posedge aclk);
    port_enable_set <= 1'b0;
    port_disable_fault <= 1'b1;
    @(posedge aclk);
    port_disable_fault <= 1'b0;
    rd(12'h004);
    chk("fault_disable", 32'(rq[1:0]), st(0, 0));
    wr(12'h010, 32'h0);
    chk("wr_unmapped", 32'(rb), 32'(upsc_pkg::resp_slverr));
    rd(12'h010);
    chk("unmapped", 32'(rr), 32'(upsc_pkg::resp_slverr));
    results();
  end
endmodule
